/* core/adc_trig_pkg.sv */
package adc_trig_pkg;

	localparam int unsigned CLK_MHZ      = 100;
	localparam int unsigned RC_TAD_NS    = 4000;
	localparam int unsigned RC_TAD_CYC   = RC_TAD_NS * CLK_MHZ / 1000;
	localparam int unsigned DIV_2        = 2;
	localparam int unsigned DIV_8        = 8;
	localparam int unsigned DIV_32       = 32;
	localparam int unsigned CNT_W        = 16;
	localparam logic [3:0]  SPECIAL_MODE = 4'hB;
	// cycles the synced comparator lags a new trial code
	localparam logic [1:0]  CMP_SETTLE   = 2'h2;

	// register indexes; byte address is four times the index
	localparam logic [7:0] IDX_PORT_A_PINS = 8'h05;
	localparam logic [7:0] IDX_PORT_E_PINS = 8'h09;
	localparam logic [7:0] IDX_INT_CTRL    = 8'h0B;
	localparam logic [7:0] IDX_FLAGS_ONE   = 8'h0C;
	localparam logic [7:0] IDX_FLAGS_TWO   = 8'h0D;
	localparam logic [7:0] IDX_RESULT      = 8'h1E;
	localparam logic [7:0] IDX_CTRL_MAIN   = 8'h1F;
	localparam logic [7:0] IDX_PORT_A_DIR  = 8'h85;
	localparam logic [7:0] IDX_PORT_E_DIR  = 8'h89;
	localparam logic [7:0] IDX_ENABLES_ONE = 8'h8C;
	localparam logic [7:0] IDX_ENABLES_TWO = 8'h8D;
	localparam logic [7:0] IDX_PIN_CONFIG  = 8'h9F;
	localparam logic [7:0] IDX_IRQ_STATUS  = 8'hA0;
	localparam logic [7:0] IDX_IRQ_MASK    = 8'hA1;

	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [5:0] RST_PORT_A_DIR = 6'h3F;
	localparam logic [2:0] RST_PORT_E_DIR = 3'h7;
	localparam logic [2:0] RST_PIN_CONFIG = 3'h0;

	localparam int unsigned DONE_FLAG_BIT = 6;
	localparam int unsigned IRQ_DONE      = 0;
	localparam int unsigned IRQ_TRIGGER   = 1;
	localparam int unsigned IRQ_ABORT     = 2;
	localparam int unsigned IRQ_W         = 3;

	typedef struct packed {
		logic [1:0] clk_sel;
		logic [2:0] chan;
		logic       go;
		logic       unused;
		logic       on;
	} conv_ctrl_t;

	// analog channels AN0..AN7 per pin configuration code
	function automatic logic [7:0] analog_mask(input logic [2:0] pcfg);
		case (pcfg)
			3'h0, 3'h1: analog_mask = 8'hFF;
			3'h2, 3'h3: analog_mask = 8'h1F;
			3'h4, 3'h5: analog_mask = 8'h0B;
			default:    analog_mask = 8'h00;
		endcase
	endfunction : analog_mask

endpackage : adc_trig_pkg

/* core/conv_clock_gen.sv */
`timescale 1ns/1ps
module conv_clock_gen (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic [1:0] clk_sel,
	output logic            tad_tick
);
	logic [adc_trig_pkg::CNT_W-1:0] cnt_reg;
	logic [adc_trig_pkg::CNT_W-1:0] cnt_next;
	logic [adc_trig_pkg::CNT_W-1:0] limit;
	logic                           tick_next;

	always_comb begin
		case (clk_sel) // R10
			2'b00:   limit = adc_trig_pkg::CNT_W'(adc_trig_pkg::DIV_2);
			2'b01:   limit = adc_trig_pkg::CNT_W'(adc_trig_pkg::DIV_8);
			2'b10:   limit = adc_trig_pkg::CNT_W'(adc_trig_pkg::DIV_32);
			default: limit = adc_trig_pkg::CNT_W'(adc_trig_pkg::RC_TAD_CYC);
		endcase
		tick_next = 1'b0;
		cnt_next = cnt_reg + 1'b1;
		if (!run) begin
			cnt_next = '0;
		end else if (cnt_reg == limit - 1'b1) begin
			cnt_next = '0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
			tad_tick <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tad_tick <= tick_next;
		end
	end

	chk_div2_period: assert property (@(posedge pclk) disable iff (!presetn)
		run && clk_sel == 2'b00 && tad_tick ##1 run && clk_sel == 2'b00
		|=> tad_tick) // R10
		else $error("divide by two period wrong");

endmodule : conv_clock_gen

/* core/sar_engine.sv */
`timescale 1ns/1ps
module sar_engine (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic       tad_tick,
	input  wire logic       cmp_hi,
	output logic [7:0]      trial,
	output logic [7:0]      result,
	output logic            done,
	output logic            busy
);
	typedef enum logic [1:0] {IDLE, SAMPLE, DECIDE, FINISH} sar_state_t;

	sar_state_t st_reg;
	sar_state_t st_next;
	logic [2:0] step_reg;
	logic [2:0] step_next;
	logic [7:0] code_reg;
	logic [7:0] code_next;
	logic [1:0] wait_reg;
	logic [1:0] wait_next;

	// a decision waits until the two-flop comparator path shows the trial
	always_comb begin
		st_next = st_reg;
		step_next = step_reg;
		code_next = code_reg;
		wait_next = (wait_reg != 2'h0) ? wait_reg - 1'b1 : 2'h0;
		case (st_reg)
			IDLE: begin
				if (run) st_next = SAMPLE;
			end
			SAMPLE: begin
				if (tad_tick) begin
					st_next = DECIDE;
					step_next = 3'h7;
					code_next = 8'h80;
					wait_next = adc_trig_pkg::CMP_SETTLE;
				end
			end
			DECIDE: begin
				if (tad_tick && wait_reg == 2'h0) begin
					wait_next = adc_trig_pkg::CMP_SETTLE;
					code_next[step_reg] = cmp_hi;
					if (step_reg == 3'h0) begin
						st_next = FINISH;
					end else begin
						step_next = step_reg - 1'b1;
						code_next[step_reg - 1'b1] = 1'b1;
					end
				end
			end
			default: st_next = IDLE;
		endcase
		if (!run) st_next = IDLE; // R9
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= IDLE;
			step_reg <= 3'h0;
			code_reg <= 8'h00;
			wait_reg <= 2'h0;
		end else begin
			st_reg <= st_next;
			step_reg <= step_next;
			code_reg <= code_next;
			wait_reg <= wait_next;
		end
	end

	assign trial = code_reg;
	assign result = code_reg;
	assign done = (st_reg == FINISH);
	assign busy = (st_reg != IDLE);

endmodule : sar_engine

/* core/adc_trigger_control.sv */
`timescale 1ns/1ps
// How it works
// R1: trigger accepted only at mode 1011 and on
// R2: accepted trigger sets go like software
// R3: every trigger clears the interval counter
// R4: converter off ignores trigger, still clears counter
// R5: software picks channel, waits acquisition first
// R6: unimplemented bits read zero
// R7: software keeps parallel port bits clear
// R8: completion stores result, clears go, sets flag
// R9: software clearing go aborts without result
// R10: clock select picks div 2/8/32 or RC
// R11: reset disables converter, pins all analog
// R12: trigger edge becomes one single-cycle pulse
module adc_trigger_control (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        special_event,
	input  wire logic [3:0]  compare_two_mode_field,
	output logic             interval_clear,
	input  wire logic        cmp_hi,
	output logic [7:0]       sar_trial,
	output logic [2:0]       input_channel_select,
	output logic             converter_on,
	output logic             conversion_busy,
	output logic [7:0]       analog_pins,
	input  wire logic [5:0]  port_a_in,
	output logic [5:0]       port_a_out,
	output logic [5:0]       port_a_oe,
	input  wire logic [2:0]  port_e_in,
	output logic [2:0]       port_e_out,
	output logic [2:0]       port_e_oe,
	output logic             irq
);
	adc_trig_pkg::conv_ctrl_t ctrl_reg;
	adc_trig_pkg::conv_ctrl_t ctrl_next;
	logic [2:0]                      pcfg_reg;
	logic [2:0]                      pcfg_next;
	logic [7:0]                      result_reg;
	logic [7:0]                      result_next;
	logic [7:0]                      intctl_reg;
	logic [7:0]                      intctl_next;
	logic [7:0]                      flags1_reg;
	logic [7:0]                      flags1_next;
	logic                            flags2_reg;
	logic                            flags2_next;
	logic [7:0]                      en1_reg;
	logic [7:0]                      en1_next;
	logic                            en2_reg;
	logic                            en2_next;
	logic [5:0]                      pa_lat_reg;
	logic [5:0]                      pa_lat_next;
	logic [5:0]                      pa_dir_reg;
	logic [5:0]                      pa_dir_next;
	logic [2:0]                      pe_lat_reg;
	logic [2:0]                      pe_lat_next;
	logic [2:0]                      pe_dir_reg;
	logic [2:0]                      pe_dir_next;
	logic                            pe_mode_reg;
	logic                            pe_mode_next;
	logic [adc_trig_pkg::IRQ_W-1:0]  ist_reg;
	logic [adc_trig_pkg::IRQ_W-1:0]  ist_next;
	logic [adc_trig_pkg::IRQ_W-1:0]  imask_reg;
	logic [adc_trig_pkg::IRQ_W-1:0]  imask_next;
	logic [31:0]                     prdata_next;
	logic                            err_reg;
	logic                            err_next;
	logic                            se_prev_reg;
	logic                            clr_reg;
	logic [9:0]                      sync1_reg;
	logic [9:0]                      sync2_reg;
	logic                            se_pulse;
	logic                            accept;
	logic [7:0]                      idx;
	logic                            wr;
	logic                            mapped;
	logic [7:0]                      rd8;
	logic [7:0]                      an;
	logic [5:0]                      pa_analog;
	logic                            tad_tick;
	logic                            eng_done;
	logic                            eng_busy;
	logic [7:0]                      eng_result;
	logic                            finish;
	logic                            abort;
	logic                            run;

	// pins and comparator are asynchronous
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 10'h000;
			sync2_reg <= 10'h000;
		end else begin
			sync1_reg <= {cmp_hi, port_e_in, port_a_in};
			sync2_reg <= sync1_reg;
		end
	end

	// trigger edge detect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			se_prev_reg <= 1'b0;
			clr_reg <= 1'b0;
		end else begin
			se_prev_reg <= special_event;
			clr_reg <= se_pulse; // R3 R4
		end
	end

	assign se_pulse = special_event & ~se_prev_reg; // R12
	assign accept = se_pulse && ctrl_reg.on
		&& compare_two_mode_field == adc_trig_pkg::SPECIAL_MODE; // R1
	assign interval_clear = clr_reg;

	// apb decode
	assign idx = paddr[9:2];
	assign wr = psel & penable & pwrite;
	assign pready = psel & penable;
	assign run = ctrl_reg.go & ctrl_reg.on;
	assign finish = eng_done & ctrl_reg.go;
	assign an = adc_trig_pkg::analog_mask(pcfg_reg);
	assign pa_analog = {an[4], 1'b0, an[3:0]};

	always_comb begin
		mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
		rd8 = 8'h00; // R6
		case (idx)
			adc_trig_pkg::IDX_PORT_A_PINS:
				rd8 = {2'b00, sync2_reg[5:0] & ~pa_analog};
			adc_trig_pkg::IDX_PORT_E_PINS:
				rd8 = {5'h00, sync2_reg[8:6] & ~an[7:5]};
			adc_trig_pkg::IDX_INT_CTRL:    rd8 = intctl_reg;
			adc_trig_pkg::IDX_FLAGS_ONE:   rd8 = flags1_reg;
			adc_trig_pkg::IDX_FLAGS_TWO:   rd8 = {7'h00, flags2_reg};
			adc_trig_pkg::IDX_RESULT:      rd8 = result_reg;
			adc_trig_pkg::IDX_CTRL_MAIN:   rd8 = {ctrl_reg[7:2], 1'b0,
				ctrl_reg.on}; // R6
			adc_trig_pkg::IDX_PORT_A_DIR:  rd8 = {2'b00, pa_dir_reg};
			adc_trig_pkg::IDX_PORT_E_DIR:
				rd8 = {3'h0, pe_mode_reg, 1'b0, pe_dir_reg};
			adc_trig_pkg::IDX_ENABLES_ONE: rd8 = en1_reg;
			adc_trig_pkg::IDX_ENABLES_TWO: rd8 = {7'h00, en2_reg};
			adc_trig_pkg::IDX_PIN_CONFIG:  rd8 = {5'h00, pcfg_reg};
			adc_trig_pkg::IDX_IRQ_STATUS:  rd8 = {5'h00, ist_reg};
			adc_trig_pkg::IDX_IRQ_MASK:    rd8 = {5'h00, imask_reg};
			default: mapped = 1'b0;
		endcase
		prdata_next = prdata;
		err_next = err_reg;
		if (psel && !penable) begin
			prdata_next = mapped ? {24'h000000, rd8} : 32'h00000000;
			err_next = ~mapped;
		end
	end

	assign pslverr = pready & err_reg;

	// register updates
	always_comb begin
		ctrl_next = ctrl_reg;
		pcfg_next = pcfg_reg;
		result_next = result_reg;
		intctl_next = intctl_reg;
		flags1_next = flags1_reg;
		flags2_next = flags2_reg;
		en1_next = en1_reg;
		en2_next = en2_reg;
		pa_lat_next = pa_lat_reg;
		pa_dir_next = pa_dir_reg;
		pe_lat_next = pe_lat_reg;
		pe_dir_next = pe_dir_reg;
		pe_mode_next = pe_mode_reg;
		imask_next = imask_reg;
		ist_next = ist_reg;
		abort = 1'b0;
		if (wr && mapped) begin
			case (idx)
				adc_trig_pkg::IDX_PORT_A_PINS: pa_lat_next = pwdata[5:0];
				adc_trig_pkg::IDX_PORT_E_PINS: pe_lat_next = pwdata[2:0];
				adc_trig_pkg::IDX_INT_CTRL:    intctl_next = pwdata[7:0];
				adc_trig_pkg::IDX_FLAGS_ONE:   flags1_next = pwdata[7:0];
				adc_trig_pkg::IDX_FLAGS_TWO:   flags2_next = pwdata[0];
				adc_trig_pkg::IDX_CTRL_MAIN: begin
					ctrl_next = pwdata[7:0];
					ctrl_next.unused = 1'b0; // R6
					abort = eng_busy & ctrl_reg.go & ~pwdata[2]; // R9
				end
				adc_trig_pkg::IDX_PORT_A_DIR:  pa_dir_next = pwdata[5:0];
				adc_trig_pkg::IDX_PORT_E_DIR: begin
					pe_dir_next = pwdata[2:0];
					pe_mode_next = pwdata[4];
				end
				adc_trig_pkg::IDX_ENABLES_ONE: en1_next = pwdata[7:0];
				adc_trig_pkg::IDX_ENABLES_TWO: en2_next = pwdata[0];
				adc_trig_pkg::IDX_PIN_CONFIG:  pcfg_next = pwdata[2:0];
				adc_trig_pkg::IDX_IRQ_STATUS:
					ist_next = ist_reg & ~pwdata[adc_trig_pkg::IRQ_W-1:0];
				adc_trig_pkg::IDX_IRQ_MASK:
					imask_next = pwdata[adc_trig_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
		if (finish) begin
			result_next = eng_result; // R8
			ctrl_next.go = 1'b0; // R8
			flags1_next[adc_trig_pkg::DONE_FLAG_BIT] = 1'b1; // R8
			ist_next[adc_trig_pkg::IRQ_DONE] = 1'b1;
		end
		if (accept) begin
			ctrl_next.go = 1'b1; // R2
			ist_next[adc_trig_pkg::IRQ_TRIGGER] = 1'b1;
		end
		if (abort) ist_next[adc_trig_pkg::IRQ_ABORT] = 1'b1;
		if (!ctrl_next.on) ctrl_next.go = 1'b0; // R4
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= adc_trig_pkg::RST_ZERO; // R11
			pcfg_reg <= adc_trig_pkg::RST_PIN_CONFIG; // R11
			result_reg <= adc_trig_pkg::RST_ZERO;
			intctl_reg <= adc_trig_pkg::RST_ZERO;
			flags1_reg <= adc_trig_pkg::RST_ZERO;
			flags2_reg <= 1'b0;
			en1_reg <= adc_trig_pkg::RST_ZERO;
			en2_reg <= 1'b0;
			pa_lat_reg <= 6'h00;
			pa_dir_reg <= adc_trig_pkg::RST_PORT_A_DIR;
			pe_lat_reg <= 3'h0;
			pe_dir_reg <= adc_trig_pkg::RST_PORT_E_DIR;
			pe_mode_reg <= 1'b0;
			ist_reg <= '0;
			imask_reg <= '0;
			prdata <= 32'h00000000;
			err_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			pcfg_reg <= pcfg_next;
			result_reg <= result_next;
			intctl_reg <= intctl_next;
			flags1_reg <= flags1_next;
			flags2_reg <= flags2_next;
			en1_reg <= en1_next;
			en2_reg <= en2_next;
			pa_lat_reg <= pa_lat_next;
			pa_dir_reg <= pa_dir_next;
			pe_lat_reg <= pe_lat_next;
			pe_dir_reg <= pe_dir_next;
			pe_mode_reg <= pe_mode_next;
			ist_reg <= ist_next;
			imask_reg <= imask_next;
			prdata <= prdata_next;
			err_reg <= err_next;
		end
	end

	conv_clock_gen u_clk (
		.pclk     (pclk),
		.presetn  (presetn),
		.run      (eng_busy),
		.clk_sel  (ctrl_reg.clk_sel),
		.tad_tick (tad_tick)
	);

	sar_engine u_sar (
		.pclk     (pclk),
		.presetn  (presetn),
		.run      (run),
		.tad_tick (tad_tick),
		.cmp_hi   (sync2_reg[9]),
		.trial    (sar_trial),
		.result   (eng_result),
		.done     (eng_done),
		.busy     (eng_busy)
	);

	assign irq = |(ist_reg & imask_reg);
	assign input_channel_select = ctrl_reg.chan;
	assign converter_on = ctrl_reg.on;
	assign conversion_busy = eng_busy;
	assign analog_pins = an; // R11
	assign port_a_out = pa_lat_reg;
	assign port_a_oe = ~pa_dir_reg;
	assign port_e_out = pe_lat_reg;
	assign port_e_oe = ~pe_dir_reg;

	logic ctrl_wr;
	assign ctrl_wr = wr && mapped && idx == adc_trig_pkg::IDX_CTRL_MAIN;

	sequence trig_taken;
		se_pulse && ctrl_reg.on
			&& compare_two_mode_field == adc_trig_pkg::SPECIAL_MODE;
	endsequence

	sequence conv_end;
		eng_done && ctrl_reg.go && !accept;
	endsequence

	chk_trigger_sets_go: assert property (@(posedge pclk) // R1 R2
		disable iff (!presetn) (trig_taken and !ctrl_wr) |=> ctrl_reg.go)
		else $error("accepted trigger did not set go");

	chk_wrong_mode: assert property (@(posedge pclk) // R1
		disable iff (!presetn)
		se_pulse && compare_two_mode_field != adc_trig_pkg::SPECIAL_MODE
		&& !ctrl_reg.go && !ctrl_wr |=> !ctrl_reg.go)
		else $error("trigger in wrong mode started conversion");

	chk_counter_clear: assert property (@(posedge pclk) // R3
		disable iff (!presetn) se_pulse |=> interval_clear)
		else $error("trigger did not clear interval counter");

	chk_off_ignored: assert property (@(posedge pclk) // R4
		disable iff (!presetn) se_pulse && !ctrl_reg.on && !ctrl_wr
		|=> !ctrl_reg.go && interval_clear)
		else $error("converter off but trigger acted");

	chk_unimpl_zero: assert property (@(posedge pclk) // R6
		disable iff (!presetn) pready && !pwrite
		|-> prdata[31:8] == 24'h000000)
		else $error("unimplemented bits read nonzero");

	chk_done_result: assert property (@(posedge pclk) // R8
		disable iff (!presetn) conv_end
		|=> result_reg == $past(eng_result) && !ctrl_reg.go
		&& flags1_reg[adc_trig_pkg::DONE_FLAG_BIT])
		else $error("completion did not store result");

	chk_abort_quiet: assert property (@(posedge pclk) // R9
		disable iff (!presetn) abort && !accept
		|=> ##1 $stable(result_reg) && !eng_busy)
		else $error("aborted conversion still ran");

	chk_single_pulse: assert property (@(posedge pclk) // R12
		disable iff (!presetn) interval_clear |=> !interval_clear)
		else $error("trigger pulse longer than one cycle");

endmodule : adc_trigger_control

/* tb/cmp_unit_model.sv */
`timescale 1ns/1ps
module cmp_unit_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       interval_clear,
	input  wire logic [7:0] sar_trial,
	input  wire logic [7:0] level,
	output logic            special_event,
	output logic [3:0]      mode_field,
	output logic            cmp_hi,
	output logic [15:0]     interval_count
);
	// analog input against the trial code
	assign cmp_hi = (level >= sar_trial);
	initial begin
		special_event = 1'b0;
		mode_field = 4'h0;
	end
	// free-running interval counter, restarted by the clear pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			interval_count <= 16'h0000;
		else if (interval_clear)
			interval_count <= 16'h0000;
		else
			interval_count <= interval_count + 16'h0001;
	end
	// set the mode, then hold the trigger high for len cycles
	task automatic fire(input logic [3:0] m, input int len);
		mode_field <= m;
		special_event <= 1'b1;
		repeat (len) @(posedge pclk);
		special_event <= 1'b0;
		@(posedge pclk);
	endtask : fire
endmodule : cmp_unit_model

/* tb/adc_trigger_control_test.sv */
`timescale 1ns/1ps
module adc_trigger_control_test;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        special_event;
	logic [3:0]  mode_field;
	logic        interval_clear;
	logic        cmp_hi;
	logic [7:0]  sar_trial;
	logic        conversion_busy;
	logic [7:0]  analog_pins;
	logic        irq;
	logic [15:0] interval_count;
	logic [7:0]  level;
	logic [31:0] d;
	logic        e;
	int          err_count;
	int          comparisons;
	int          clears;
	int          n;
	int          m;
	int          conversion_bit_period;
	int          bt;
	logic [7:0]  lv [4];

	adc_trigger_control dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .special_event(special_event),
		.compare_two_mode_field(mode_field), .interval_clear(interval_clear),
		.cmp_hi(cmp_hi), .sar_trial(sar_trial), .input_channel_select(),
		.converter_on(), .conversion_busy(conversion_busy),
		.analog_pins(analog_pins), .port_a_in(6'h2A), .port_a_out(),
		.port_a_oe(), .port_e_in(3'h5), .port_e_out(), .port_e_oe(),
		.irq(irq)
	);
	cmp_unit_model u_cmp (
		.pclk(pclk), .presetn(presetn), .interval_clear(interval_clear),
		.sar_trial(sar_trial), .level(level), .special_event(special_event),
		.mode_field(mode_field), .cmp_hi(cmp_hi),
		.interval_count(interval_count)
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (interval_clear === 1'b1)
			clears <= clears + 1;
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] idx,
			input logic [7:0] wd, output logic [31:0] rdat, output logic err);
		int k;
		k = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			k++;
			if (k > 20) begin
				err_count++;
				$display("wrong value at %0t: no ready", $time);
				summarize();
			end
			@(posedge pclk);
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		apb(1'b1, idx, wd, d, e);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00, d, e);
		check(d, {24'h000000, exp});
	endtask : rd

	// waits for a conversion to start and end, returns its busy cycles
	task automatic conv_wait(output int cyc);
		int k;
		k = 0;
		cyc = 0;
		while (conversion_busy !== 1'b1 && k < 10) begin
			@(negedge pclk);
			k++;
		end
		while (conversion_busy === 1'b1 && cyc < 5000) begin
			@(negedge pclk);
			cyc++;
		end
		if (conversion_busy !== 1'b0) begin
			err_count++;
			$display("wrong value at %0t: conversion hangs", $time);
			summarize();
		end
		@(posedge pclk);
	endtask : conv_wait

	function automatic logic [7:0] ctrl(input logic [1:0] s,
			input logic [2:0] ch, input logic go, input logic on);
		ctrl = {s, ch, go, 1'b0, on};
	endfunction : ctrl

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		level = 8'h00;
		clears = 0;
		err_count = 0;
		comparisons = 0;
		lv = '{8'h00, 8'hFF, 8'h81, 8'h5C};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(adc_trig_pkg::IDX_CTRL_MAIN, 8'h00);
		rd(adc_trig_pkg::IDX_PIN_CONFIG, 8'h00);
		rd(adc_trig_pkg::IDX_PORT_A_DIR, 8'h3F);
		rd(adc_trig_pkg::IDX_PORT_E_DIR, 8'h07);
		rd(adc_trig_pkg::IDX_FLAGS_ONE, 8'h00);
		rd(adc_trig_pkg::IDX_PORT_A_PINS, 8'h00);
		check(analog_pins, 8'hFF);
		wr(adc_trig_pkg::IDX_RESULT, 8'h5A);
		rd(adc_trig_pkg::IDX_RESULT, 8'h00);
		wr(adc_trig_pkg::IDX_CTRL_MAIN, 8'h02);
		rd(adc_trig_pkg::IDX_CTRL_MAIN, 8'h00);
		apb(1'b0, 8'h40, 8'h00, d, e);
		check({31'h0, e}, 1);
		check(d, 0);
		$display("test reset and map done");
		for (int s = 0; s < 4; s++) begin
			level <= lv[s];
			conversion_bit_period = (s == 3) ? adc_trig_pkg::RC_TAD_CYC : 2 << (2 * s);
			// a bit needs a whole tick past the comparator settle time
			bt = (conversion_bit_period > adc_trig_pkg::CMP_SETTLE) ? conversion_bit_period : 2 * conversion_bit_period;
			wr(adc_trig_pkg::IDX_CTRL_MAIN, ctrl(2'(s), 3'h2, 1'b0, 1'b1));
			wr(adc_trig_pkg::IDX_CTRL_MAIN, ctrl(2'(s), 3'h2, 1'b1, 1'b1));
			conv_wait(n);
			check(n >= 8 * bt && n <= 10 * bt + 8, 1);
			rd(adc_trig_pkg::IDX_RESULT, lv[s]);
			rd(adc_trig_pkg::IDX_CTRL_MAIN, ctrl(2'(s), 3'h2, 1'b0, 1'b1));
			rd(adc_trig_pkg::IDX_FLAGS_ONE, 8'h40);
			wr(adc_trig_pkg::IDX_FLAGS_ONE, 8'h00);
		end
		$display("test software conversions done");
		level <= 8'h3C;
		wr(adc_trig_pkg::IDX_CTRL_MAIN, ctrl(2'h0, 3'h5, 1'b0, 1'b1));
		u_cmp.fire(4'hA, 1);
		repeat (3) @(posedge pclk);
		check(conversion_busy, 0);
		rd(adc_trig_pkg::IDX_CTRL_MAIN, ctrl(2'h0, 3'h5, 1'b0, 1'b1));
		m = clears;
		u_cmp.fire(4'hB, 1);
		repeat (2) @(posedge pclk);
		check(interval_count < 16'h0004, 1);
		check(clears, m + 1);
		rd(adc_trig_pkg::IDX_CTRL_MAIN, ctrl(2'h0, 3'h5, 1'b1, 1'b1));
		conv_wait(n);
		rd(adc_trig_pkg::IDX_RESULT, 8'h3C);
		m = clears;
		u_cmp.fire(4'hB, 6);
		conv_wait(n);
		check(clears, m + 1);
		wr(adc_trig_pkg::IDX_FLAGS_ONE, 8'h00);
		wr(adc_trig_pkg::IDX_CTRL_MAIN, ctrl(2'h0, 3'h5, 1'b0, 1'b0));
		repeat (40) @(posedge pclk);
		m = clears;
		u_cmp.fire(4'hB, 1);
		repeat (2) @(posedge pclk);
		check(interval_count < 16'h0004, 1);
		check(clears, m + 1);
		check(conversion_busy, 0);
		rd(adc_trig_pkg::IDX_CTRL_MAIN, ctrl(2'h0, 3'h5, 1'b0, 1'b0));
		$display("test trigger done");
		wr(adc_trig_pkg::IDX_IRQ_MASK, 8'h00);
		rd(adc_trig_pkg::IDX_IRQ_STATUS, 8'h03);
		check(irq, 0);
		wr(adc_trig_pkg::IDX_IRQ_MASK, 8'h01);
		check(irq, 1);
		wr(adc_trig_pkg::IDX_IRQ_STATUS, 8'h07);
		check(irq, 0);
		rd(adc_trig_pkg::IDX_IRQ_STATUS, 8'h00);
		$display("test interrupt done");
		level <= 8'hC3;
		wr(adc_trig_pkg::IDX_CTRL_MAIN, ctrl(2'h3, 3'h1, 1'b0, 1'b1));
		wr(adc_trig_pkg::IDX_CTRL_MAIN, ctrl(2'h3, 3'h1, 1'b1, 1'b1));
		repeat (100) @(posedge pclk);
		wr(adc_trig_pkg::IDX_CTRL_MAIN, ctrl(2'h3, 3'h1, 1'b0, 1'b1));
		conv_wait(n);
		rd(adc_trig_pkg::IDX_RESULT, 8'h3C);
		rd(adc_trig_pkg::IDX_FLAGS_ONE, 8'h00);
		rd(adc_trig_pkg::IDX_IRQ_STATUS, 8'h04);
		check(irq, 0);
		$display("test abort done");
		wr(adc_trig_pkg::IDX_PIN_CONFIG, 8'h06);
		check(analog_pins, 8'h00);
		rd(adc_trig_pkg::IDX_PORT_A_PINS, 8'h2A);
		wr(adc_trig_pkg::IDX_CTRL_MAIN, ctrl(2'h3, 3'h1, 1'b1, 1'b1));
		repeat (50) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(conversion_busy, 0);
		check(analog_pins, 8'hFF);
		rd(adc_trig_pkg::IDX_CTRL_MAIN, 8'h00);
		$display("test mid-run reset done");
		summarize();
	end
endmodule : adc_trigger_control_test
